// ==== inc/cgfm_defines.vh ====
`ifndef CGFM_DEFINES_VH
`define CGFM_DEFINES_VH

// Core clock rate
`define CGFM_CLK_HZ        100000000

// Reference timer rate, must lie in 10 kHz .. 100 kHz
`define CGFM_REF_MIN_HZ    10000
`define CGFM_REF_MAX_HZ    100000
`define CGFM_REF_HZ        50000
`define CGFM_REF_CYCLES    (`CGFM_CLK_HZ / `CGFM_REF_HZ)
`define CGFM_REF_CNT_W     11

// Local memory bus rates; 64 MHz crystal divided by 16 gives 4 MHz
`define CGFM_XTAL_HZ       64000000
`define CGFM_MB_SLOW_HZ    4000000
`define CGFM_MB_FAST_HZ    6000000
`define CGFM_MB_SLOW_CYC   (`CGFM_CLK_HZ / `CGFM_MB_SLOW_HZ)
`define CGFM_MB_FAST_CYC   (`CGFM_CLK_HZ / `CGFM_MB_FAST_HZ)
`define CGFM_MB_CNT_W      5

// Monitored clock positions in the failure vector
`define CGFM_NUM_CLK       4
`define CGFM_IDX_SYS_BUS   0
`define CGFM_IDX_OSC       1
`define CGFM_IDX_RX        2
`define CGFM_IDX_PHY_XTAL  3

// Supervisor states, one-hot
`define CGFM_ST_RUN        3'h1
`define CGFM_ST_DRAIN      3'h2
`define CGFM_ST_SLOW       3'h4

`endif

// ==== verilog/cgfm_edge_mon.v ====
`include "cgfm_defines.vh"

// Transition detector for one foreign clock, sampled by three flip-flops.
// A change counts only once the second and third stages agree, so a
// metastable first stage never reaches the flag.
module cgfm_edge_mon
(
  input  wire clk,
  input  wire rst,
  input  wire clk_in,
  input  wire period_end,
  output reg  seen
);

  reg sync_a;
  reg sync_b;
  reg sync_c;
  reg stable;

  wire change = (sync_b == sync_c) && (sync_c != stable);

  always @(posedge clk)
  begin
    if (rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      stable <= 1'b0;
      seen   <= 1'b0;
    end
    else
    begin
      sync_a <= clk_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (change)
        stable <= sync_c;
      // A transition in the closing cycle opens the next period as seen
      if (change)
        seen <= 1'b1;
      else if (period_end)
        seen <= 1'b0;
    end
  end

endmodule

// ==== verilog/cgfm_top.v ====
// Summary of operation
// - Enter slow-clock mode if a watched clock stays still one period.
// - Reference timer runs somewhere between 10 kHz and 100 kHz.
// - Watch system-bus, oscillator, receive and PHY crystal clocks.
// - Slow mode swaps in a slow free-running clock; low-power reset held.
// - Generate both local memory-bus clocks and internal clock enables.
// - Memory bus runs at 4 MHz, optionally at 6.25 MHz (16 core cycles).
// - System-bus clock failure aborts DMA at once, else DMA completes first.
`include "cgfm_defines.vh"

module cgfm_top
(
  input  wire       clk,
  input  wire       rst,
  input  wire       system_bus_clock_in,
  input  wire       oscillator_clock_in,
  input  wire       receive_clock_in,
  input  wire       phy_crystal_clock_in,
  input  wire       mem_bus_fast,
  input  wire       dma_active,
  input  wire       host_reinit,
  output reg        mem_bus_clock_one,
  output reg        mem_bus_clock_two,
  output reg        slow_clock,
  output reg        ref_tick,
  output reg        core_clk_en,
  output reg  [3:0] clock_failed,
  output reg        slow_mode,
  output reg        device_reset,
  output reg        dma_abort
);

  localparam integer               REF_LAST_N = `CGFM_REF_CYCLES - 1;
  localparam integer               MB_SLOW_N  = `CGFM_MB_SLOW_CYC;
  localparam integer               MB_FAST_N  = `CGFM_MB_FAST_CYC;
  localparam [`CGFM_REF_CNT_W-1:0] REF_LAST = REF_LAST_N[`CGFM_REF_CNT_W-1:0];
  localparam [`CGFM_MB_CNT_W-1:0]  MB_SLOW  = MB_SLOW_N[`CGFM_MB_CNT_W-1:0];
  localparam [`CGFM_MB_CNT_W-1:0]  MB_FAST  = MB_FAST_N[`CGFM_MB_CNT_W-1:0];
  localparam [2:0]                 ST_RUN   = `CGFM_ST_RUN;
  localparam [2:0]                 ST_DRAIN = `CGFM_ST_DRAIN;
  localparam [2:0]                 ST_SLOW  = `CGFM_ST_SLOW;

  reg  [`CGFM_REF_CNT_W-1:0] ref_cnt;
  reg  [`CGFM_MB_CNT_W-1:0]  mb_cnt;
  reg  [2:0]                 state;
  reg  [2:0]                 next_state;
  reg  [3:0]                 fail_latch;
  wire [3:0]                 clk_pins;
  wire [3:0]                 seen;
  wire                       period_end;
  wire [`CGFM_MB_CNT_W-1:0]  mb_period;
  wire [`CGFM_MB_CNT_W-1:0]  mb_half;
  wire [`CGFM_MB_CNT_W-1:0]  mb_quarter;
  wire [`CGFM_MB_CNT_W-1:0]  mb_three_q;
  wire [3:0]                 fail_now;
  wire                       any_fail;
  wire                       next_slow_clock;

  assign clk_pins[`CGFM_IDX_SYS_BUS]  = system_bus_clock_in;
  assign clk_pins[`CGFM_IDX_OSC]      = oscillator_clock_in;
  assign clk_pins[`CGFM_IDX_RX]       = receive_clock_in;
  assign clk_pins[`CGFM_IDX_PHY_XTAL] = phy_crystal_clock_in;

  // Reference timer: one period of REF_CYCLES core cycles (50 kHz)
  assign period_end = (ref_cnt == REF_LAST);

  always @(posedge clk)
  begin
    if (rst)
    begin
      ref_cnt  <= {`CGFM_REF_CNT_W{1'b0}};
      ref_tick <= 1'b0;
    end
    else
    begin
      ref_tick <= period_end;
      if (period_end)
        ref_cnt <= {`CGFM_REF_CNT_W{1'b0}};
      else
        ref_cnt <= ref_cnt + 1'b1;
    end
  end

  // Inputs above half the core rate alias and may look stopped
  genvar i;
  generate
    for (i = 0; i < `CGFM_NUM_CLK; i = i + 1)
    begin : g_mon
      cgfm_edge_mon u_mon
      (
        .clk        (clk),
        .rst        (rst),
        .clk_in     (clk_pins[i]),
        .period_end (period_end),
        .seen       (seen[i])
      );
    end
  endgenerate

  // A flag still clear at the period end means no transition all period
  assign fail_now = period_end ? ~seen : 4'h0;
  assign any_fail = |fail_now;

  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (any_fail && (fail_now[`CGFM_IDX_SYS_BUS] || !dma_active))
          next_state = ST_SLOW;
        else if (any_fail)
          next_state = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        if (!dma_active || fail_now[`CGFM_IDX_SYS_BUS])
          next_state = ST_SLOW;
      end
      ST_SLOW:
      begin
        // Held until the host reinitializes the device
        if (host_reinit)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_SLOW;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state        <= ST_RUN;
      fail_latch   <= 4'h0;
      clock_failed <= 4'h0;
      slow_mode    <= 1'b0;
      device_reset <= 1'b0;
      dma_abort    <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_SLOW && host_reinit)
        fail_latch <= fail_now;
      else
        fail_latch <= fail_latch | fail_now;
      if (state == ST_SLOW && host_reinit)
        clock_failed <= fail_now;
      else
        clock_failed <= fail_latch | fail_now;
      slow_mode    <= (next_state == ST_SLOW);
      device_reset <= (next_state == ST_SLOW);
      // Abort only when the system-bus clock itself is the failed one
      dma_abort <= dma_active && fail_now[`CGFM_IDX_SYS_BUS] &&
                   (state != ST_SLOW);
    end
  end

  // Memory-bus divider; 6 MHz rounds down to a whole count of 16 core cycles
  assign mb_period  = mem_bus_fast ? MB_FAST : MB_SLOW;
  assign mb_half    = {1'b0, mb_period[`CGFM_MB_CNT_W-1:1]};
  assign mb_quarter = {2'b00, mb_period[`CGFM_MB_CNT_W-1:2]};
  assign mb_three_q = mb_half + mb_quarter;

  // Bus clocks take the new slow level (clock two its inverse) so they never lag it by a cycle
  assign next_slow_clock = period_end ? ~slow_clock : slow_clock;

  always @(posedge clk)
  begin
    if (rst)
    begin
      mb_cnt            <= {`CGFM_MB_CNT_W{1'b0}};
      mem_bus_clock_one <= 1'b0;
      mem_bus_clock_two <= 1'b0;
      slow_clock        <= 1'b0;
      core_clk_en       <= 1'b0;
    end
    else
    begin
      if (mb_cnt >= mb_period - 1'b1)
        mb_cnt <= {`CGFM_MB_CNT_W{1'b0}};
      else
        mb_cnt <= mb_cnt + 1'b1;
      // Slow clock runs free from the reference timer, even in slow mode
      slow_clock <= next_slow_clock;
      if (next_state == ST_SLOW)
      begin
        mem_bus_clock_one <= next_slow_clock;
        mem_bus_clock_two <= ~next_slow_clock;
        core_clk_en       <= period_end;
      end
      else
      begin
        // Second clock lags the first by a quarter period
        mem_bus_clock_one <= (mb_cnt < mb_half);
        mem_bus_clock_two <= (mb_cnt >= mb_quarter) &&
                             (mb_cnt < mb_three_q);
        core_clk_en       <= 1'b1;
      end
    end
  end

endmodule

// ==== dv/cgfm_checker.sv ====
module cgfm_checker
(
  input wire       clk,
  input wire       rst,
  input wire       host_reinit,
  input wire       mem_bus_clock_one,
  input wire       mem_bus_clock_two,
  input wire       slow_clock,
  input wire       ref_tick,
  input wire       core_clk_en,
  input wire [3:0] clock_failed,
  input wire       slow_mode,
  input wire       device_reset,
  input wire       dma_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] gap;
  logic        had;
  // First tick after reset has no predecessor to measure from
  always @(posedge clk)
  begin
    gap <= (rst || ref_tick) ? 12'h000 : gap + 12'h001;
    had <= rst ? 1'b0 : (had | ref_tick);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_reinit;
    slow_mode ##0 host_reinit;
  endsequence
  a_tick_gap: assert property (ref_tick && had |-> gap == 12'h7CF)
    else $error("reference tick spacing wrong");
  a_slow_tog: assert property ($changed(slow_clock) |-> ref_tick)
    else $error("slow clock toggled off period");
  a_reset_hold: assert property (device_reset == slow_mode)
    else $error("device reset differs from slow mode");
  a_mb_follow: assert property (slow_mode && $past(slow_mode) |->
    mem_bus_clock_one == slow_clock && mem_bus_clock_two != slow_clock)
    else $error("memory bus clocks not on slow clock");
  a_run_en: assert property (!slow_mode && !$past(slow_mode)
    && !$past(rst) |-> core_clk_en)
    else $error("core enable low in normal run");
  a_abort_once: assert property (dma_abort |=> !dma_abort)
    else $error("abort longer than one cycle");
  a_abort_why: assert property (dma_abort |-> clock_failed[0])
    else $error("abort without system bus failure");
  a_enter_slow: assert property (
    $rose(slow_mode) |-> clock_failed != 4'h0)
    else $error("slow mode without failed clock");
  a_slow_stay: assert property (
    slow_mode && !host_reinit |=> slow_mode)
    else $error("slow mode left by itself");
  a_reinit_exit: assert property (s_reinit |=> !slow_mode)
    else $error("reinit did not leave slow mode");
  a_fail_sticky: assert property (!host_reinit |=>
    ($past(clock_failed) & ~clock_failed) == 4'h0)
    else $error("failed mask bit dropped");
endmodule

bind cgfm_top cgfm_checker u_chk
(
  .clk(clk), .rst(rst), .host_reinit(host_reinit),
  .mem_bus_clock_one(mem_bus_clock_one),
  .mem_bus_clock_two(mem_bus_clock_two), .slow_clock(slow_clock),
  .ref_tick(ref_tick), .core_clk_en(core_clk_en),
  .clock_failed(clock_failed), .slow_mode(slow_mode),
  .device_reset(device_reset), .dma_abort(dma_abort)
);

// ==== dv/cgfm_clk_src.sv ====
// Four free clock sources; a stopped one freezes at its last level
module cgfm_clk_src
(
  input  wire logic [3:0] run,
  output logic      [3:0] clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial clk_out = 4'h0;
  always #20 if (run[0]) clk_out[0] = ~clk_out[0];
  always #25 if (run[1]) clk_out[1] = ~clk_out[1];
  always #30 if (run[2]) clk_out[2] = ~clk_out[2];
  always #35 if (run[3]) clk_out[3] = ~clk_out[3];
endmodule

// ==== dv/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       fast = 1'b0;
  logic       dma = 1'b0;
  logic       reinit = 1'b0;
  logic [3:0] run = 4'hF;
  logic [3:0] mon;
  logic       mb1, mb2, slw, tick, cen, smode, dres, abort;
  logic [3:0] failed;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  cgfm_clk_src SRC (.run(run), .clk_out(mon));
  cgfm_top DUT
  (
    .clk(clk), .rst(rst), .system_bus_clock_in(mon[0]),
    .oscillator_clock_in(mon[1]), .receive_clock_in(mon[2]),
    .phy_crystal_clock_in(mon[3]), .mem_bus_fast(fast),
    .dma_active(dma), .host_reinit(reinit), .mem_bus_clock_one(mb1),
    .mem_bus_clock_two(mb2), .slow_clock(slw), .ref_tick(tick),
    .core_clk_en(cen), .clock_failed(failed), .slow_mode(smode),
    .device_reset(dres), .dma_abort(abort)
  );
  initial forever #5 clk = ~clk;
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic tick_wait();
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 2100);
  endtask
  // Stop mid-period so the first period end still saw edges
  task automatic stop_clock(int i);
    tick_wait();
    repeat (1000) @(negedge clk);
    run[i] = 1'b0;
    tick_wait();
    chk(smode, 8'h0);
    tick_wait();
  endtask
  task automatic recover(int i);
    run[i] = 1'b1;
    tick_wait();
    tick_wait();
    chk(smode, 8'h1);
    reinit = 1'b1;
    @(negedge clk);
    reinit = 1'b0;
    chk(smode, 8'h0);
    chk(failed, 8'h0);
  endtask
  task automatic mb_period(logic f, int which, logic [7:0] exp);
    time t0;
    fast = f;
    repeat (60) @(negedge clk);
    if (which == 1) @(posedge mb1); else @(posedge mb2);
    t0 = $time;
    if (which == 1) @(posedge mb1); else @(posedge mb2);
    chk(8'(($time - t0) / 10), exp);
  endtask
  task automatic t_normal();
    tick_wait();
    chk({smode, dres, cen, failed}, 8'h10);
    reinit = 1'b1;
    @(negedge clk);
    reinit = 1'b0;
    chk(smode, 8'h0);
    mb_period(1'b0, 1, 8'h19);
    mb_period(1'b1, 2, 8'h10);
    fast = 1'b0;
  endtask
  task automatic t_plain_fail(int i, logic [3:0] bit_exp);
    stop_clock(i);
    chk({smode, dres, failed}, {2'b00, 2'b11, bit_exp});
    chk(mb1, slw);
    chk(mb2, {7'h00, ~slw});
    recover(i);
  endtask
  task automatic t_sys_abort();
    dma = 1'b1;
    stop_clock(0);
    chk({abort, smode, failed}, 8'h31);
    dma = 1'b0;
    recover(0);
  endtask
  task automatic t_drain();
    dma = 1'b1;
    stop_clock(2);
    repeat (5) @(negedge clk);
    chk({abort, smode}, 8'h0);
    dma = 1'b0;
    repeat (3) @(negedge clk);
    chk({smode, failed}, 8'h14);
    recover(2);
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_normal();
    t_plain_fail(1, 4'h2);
    t_plain_fail(3, 4'h8);
    t_sys_abort();
    t_drain();
    report_and_stop();
  end
endmodule
